/* core/esm_defs.svh */
`ifndef ESM_DEFS_SVH
`define ESM_DEFS_SVH

// Register byte offsets
`define ESM_REG_CTRL 8'h00
`define ESM_REG_ENC1_TYPE 8'h04
`define ESM_REG_ENC2_TYPE 8'h08
`define ESM_REG_MEAS_TYPE 8'h0C
`define ESM_REG_SINE_NOM 8'h10
`define ESM_REG_RES_SUPPLY 8'h14
`define ESM_REG_RES_RATIO 8'h18
`define ESM_REG_MARK_DIST 8'h1C
`define ESM_REG_WIN1 8'h20
`define ESM_REG_WIN2 8'h24
`define ESM_REG_DIFF_WIN 8'h28
`define ESM_REG_VAL_UPPER 8'h2C
`define ESM_REG_VAL_LOWER 8'h30
`define ESM_REG_VAL_FACTOR 8'h34
`define ESM_REG_REACTION 8'h38
`define ESM_REG_BUF1 8'h3C
`define ESM_REG_BUF2 8'h40
`define ESM_REG_STATUS 8'h44
`define ESM_REG_POS_DIFF 8'h48
`define ESM_REG_POS_STAT 8'h4C

// Encoder type fields
`define ESM_TYPE_KIND_LSB 0
`define ESM_TYPE_ABS_BIT 8
`define ESM_TYPE_MARK_BIT 9
`define ESM_CTRL_DIFF_EN_BIT 0

// Status flag positions
`define ESM_F_ENC1_WARN 0
`define ESM_F_ENC2_WARN 1
`define ESM_F_ENC1_INCORR 2
`define ESM_F_ENC2_INCORR 3
`define ESM_F_ENC1_WIN 4
`define ESM_F_ENC2_WIN 5
`define ESM_F_EXC_DIFF 6
`define ESM_F_MOT_REF 7
`define ESM_F_EXT_REF 8
`define ESM_F_MECH_LINK 9
`define ESM_F_MARK0 10
`define ESM_NUM_FLAGS 13
`define ESM_WARN_MASK 13'h0003

// Amplitude limits as squared percentages
`define ESM_SINE_LO_SQ 8'd4
`define ESM_SINE_HI_SQ 8'd196
`define ESM_RES_LO_SQ 8'd25
`define ESM_RES_HI_SQ 8'd144
`define ESM_PCT_SQ 8'd100

// Timing and phases
`define ESM_PERSIST_CNT 8'd16
`define ESM_PHASE_TWO 3'd2
`define ESM_PHASE_FOUR 3'd4
`define ESM_RES_RATIO_SHIFT 8
`define ESM_FACTOR_UNIT 3

// Reset values
`define ESM_RST_SINE_NOM 16'h1000
`define ESM_RST_FACTOR 16'h0008
`define ESM_RST_TYPE 16'h0000

`endif

/* core/esm_pkg.sv */
`include "esm_defs.svh"
package esm_pkg;
	// Encoder kind selected in the type registers
	typedef enum logic [1:0] {ESM_KIND_SINE, ESM_KIND_RES, ESM_KIND_SQUARE, ESM_KIND_NONE} esm_kind_t;
	// Monitor life cycle
	typedef enum logic {ESM_OFF, ESM_RUN} esm_mode_t;
	// One encoder front end sample
	typedef struct packed {
		logic smp_valid;
		logic signed [15:0] trk_a;
		logic signed [15:0] trk_b;
		logic [31:0] pos;
		logic mark_valid;
		logic [31:0] mark_pos;
	} esm_enc_t;
	// APB request
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} esm_apb_req_t;
	// APB answer
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} esm_apb_rsp_t;
	// Whole state of the monitor
	typedef struct packed {
		esm_apb_rsp_t rsp;
		esm_mode_t mode;
		logic [2:0] phase;
		logic diff_en;
		logic [2:0][15:0] enc_type;
		logic [15:0] sine_nom;
		logic [15:0] res_supply;
		logic [15:0] res_ratio;
		logic [31:0] mark_dist;
		logic [1:0][31:0] win;
		logic [31:0] diff_win;
		logic [15:0] val_upper;
		logic [15:0] val_lower;
		logic [15:0] val_factor;
		logic [1:0] reaction_cfg;
		logic [1:0][31:0] buf_pos;
		logic [12:0] flags;
		logic [31:0] pos_diff;
		logic [1:0] pos_abs;
		logic [1:0] reaction;
		logic [1:0][7:0] bad_cnt;
		logic [1:0][1:0] quad;
		logic [1:0] quad_ok;
		logic [2:0][31:0] mark_last;
		logic [2:0] mark_ok;
	} esm_state_t;
endpackage : esm_pkg

/* core/esm_top.sv */
// Operation
// - Sine amplitude between 0.2 and 1.4 nominal
// - Zero crossings step exactly one quadrant
// - Brief amplitude fault raises per-encoder warning
// - Warning latched until power-off or phase two (code clears it only on entry to phase two)
// - Count or persistent amplitude fault raises error
// - Errors trigger the configured error reaction
// - Resolver amplitude between 0.5 and 1.2 nominal
// - Resolver nominal is supply times ratio
// - Square-wave encoders get no signal checks
// - Marker checks only when type bit nine
// - Successive markers spaced exactly marker distance
// - Error beyond 1.5 marker distances past marker
// - Power-off saves both absolute positions
// - Power-on compares positions against saved windows
// - Exceeded window raises per-encoder window error
// - Coupling sound only between both thresholds
// - Threshold factor sets coupling sensitivity
// - Encoder difference over window raises error
// - Difference check from phase four, can disable
// - Zero power-on window disables that check
// - Phase two-to-four reference loss: relative, error
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "esm_defs.svh"
module esm_top (
	input wire logic mclk,
	input wire logic rst,
	input wire esm_pkg::esm_apb_req_t apb_req,
	output esm_pkg::esm_apb_rsp_t apb_rsp,
	input wire esm_pkg::esm_enc_t [2:0] enc,
	input wire logic [2:0] comm_phase,
	input wire logic power_off,
	input wire logic power_on,
	input wire logic [15:0] val_signal,
	input wire logic [1:0] ref_lost,
	output logic [12:0] flags,
	output logic [1:0] pos_abs,
	output logic [1:0] reaction
);
	import esm_pkg::*;

	// Registered and next state
	esm_state_t s_q;
	esm_state_t s_d;

	// Absolute difference of two signed positions
	function automatic logic [31:0] esm_absdiff(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] d;
		d = a - b;
		return d[31] ? 32'(-d) : d;
	endfunction : esm_absdiff

	// Squared amplitude inside the band lo..hi percent squared
	function automatic logic esm_amp_ok(input logic [32:0] sum, input logic [15:0] nom,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [47:0] lhs;
		logic [47:0] nsq;
		lhs = 48'(sum) * 48'(`ESM_PCT_SQ);
		nsq = 48'(nom) * 48'(nom);
		return (lhs >= nsq * 48'(lo)) && (lhs <= nsq * 48'(hi));
	endfunction : esm_amp_ok

	// Quadrant from track signs, counts up with angle
	function automatic logic [1:0] esm_quad(input logic signed [15:0] a, input logic signed [15:0] b);
		return {a[15], a[15] ^ b[15]};
	endfunction : esm_quad

	// Working values of the combinational process
	logic ph2_entry;
	logic ph4_entry;
	logic [12:0] set_f;
	logic [12:0] clr_f;
	logic access;
	logic hit;
	logic [31:0] rd;
	logic [15:0] res_nom;
	logic [31:0] res_prod;

	// Next-state logic
	always_comb begin
		esm_kind_t kind;
		logic [32:0] sum;
		logic chk;
		logic ok;
		logic [1:0] q;
		logic [31:0] dist15;
		logic [31:0] sig_sc;
		logic [31:0] up_sc;
		logic [31:0] lo_sc;
		kind = ESM_KIND_NONE;
		sum = '0;
		chk = 1'b0;
		ok = 1'b1;
		q = 2'b00;
		dist15 = '0;
		sig_sc = '0;
		up_sc = '0;
		lo_sc = '0;
		s_d = s_q;
		set_f = '0;
		clr_f = '0;
		rd = 32'h0000_0000;
		hit = 1'b1;
		// Phase tracking
		ph2_entry = (comm_phase == `ESM_PHASE_TWO) && (s_q.phase != `ESM_PHASE_TWO);
		ph4_entry = (comm_phase == `ESM_PHASE_FOUR) && (s_q.phase < `ESM_PHASE_FOUR);
		s_d.phase = comm_phase;
		// Resolver nominal from supply and Q8 ratio
		res_prod = 32'(s_q.res_supply) * 32'(s_q.res_ratio);
		res_nom = res_prod[`ESM_RES_RATIO_SHIFT +: 16];

		// Amplitude and quadrant checks, motor and external encoder
		for (int i = 0; i < 2; i++) begin
			kind = esm_kind_t'(s_q.enc_type[i][`ESM_TYPE_KIND_LSB +: 2]);
			sum = 33'(32'($signed(enc[i].trk_a) * $signed(enc[i].trk_a)))
				+ 33'(32'($signed(enc[i].trk_b) * $signed(enc[i].trk_b)));
			case (kind)
				ESM_KIND_SINE: begin
					chk = 1'b1;
					ok = esm_amp_ok(sum, s_q.sine_nom, `ESM_SINE_LO_SQ, `ESM_SINE_HI_SQ);
				end
				ESM_KIND_RES: begin
					chk = 1'b1;
					ok = esm_amp_ok(sum, res_nom, `ESM_RES_LO_SQ, `ESM_RES_HI_SQ);
				end
				default: begin
					// Square-wave or unused input
					chk = 1'b0;
					ok = 1'b1;
				end
			endcase
			if (s_q.mode == ESM_RUN && enc[i].smp_valid && chk) begin
				if (!ok) begin
					set_f[`ESM_F_ENC1_WARN + i] = 1'b1;
					if (s_q.bad_cnt[i] != `ESM_PERSIST_CNT) begin
						s_d.bad_cnt[i] = s_q.bad_cnt[i] + 8'd1;
					end
					if (s_q.bad_cnt[i] == `ESM_PERSIST_CNT - 8'd1) begin
						set_f[`ESM_F_ENC1_INCORR + i] = 1'b1;
					end
				end else begin
					s_d.bad_cnt[i] = 8'd0;
				end
				// Quadrant must move by zero or one step only
				q = esm_quad(enc[i].trk_a, enc[i].trk_b);
				if (s_q.quad_ok[i] && (2'(q - s_q.quad[i]) == 2'd2)) begin
					set_f[`ESM_F_ENC1_INCORR + i] = 1'b1;
				end
				s_d.quad[i] = q;
				s_d.quad_ok[i] = 1'b1;
			end else if (!chk) begin
				s_d.quad_ok[i] = 1'b0;
				s_d.bad_cnt[i] = 8'd0;
			end
		end

		// Reference marker checks, three encoders
		dist15 = s_q.mark_dist + (s_q.mark_dist >> 1);
		for (int i = 0; i < 3; i++) begin
			if (s_q.enc_type[i][`ESM_TYPE_MARK_BIT] && s_q.mode == ESM_RUN) begin
				if (enc[i].mark_valid) begin
					if (s_q.mark_ok[i] && esm_absdiff(enc[i].mark_pos, s_q.mark_last[i]) != s_q.mark_dist) begin
						set_f[`ESM_F_MARK0 + i] = 1'b1;
					end
					s_d.mark_last[i] = enc[i].mark_pos;
					s_d.mark_ok[i] = 1'b1;
				end else if (s_q.mark_ok[i] && esm_absdiff(enc[i].pos, s_q.mark_last[i]) > dist15) begin
					set_f[`ESM_F_MARK0 + i] = 1'b1;
				end
			end else begin
				s_d.mark_ok[i] = 1'b0;
			end
		end

		// Power-off save and power-on window check
		if (power_off) begin
			s_d.mode = ESM_OFF;
			s_d.buf_pos[0] = enc[0].pos;
			s_d.buf_pos[1] = enc[1].pos;
		end else if (power_on && s_q.mode == ESM_OFF) begin
			s_d.mode = ESM_RUN;
			for (int i = 0; i < 2; i++) begin
				if (s_q.enc_type[i][`ESM_TYPE_ABS_BIT] && s_q.win[i] != 32'h0000_0000
					&& esm_absdiff(enc[i].pos, s_q.buf_pos[i]) > s_q.win[i]) begin
					set_f[`ESM_F_ENC1_WIN + i] = 1'b1;
				end
			end
		end

		// Coupling validation band scaled by sensitivity factor
		sig_sc = 32'(val_signal) << `ESM_FACTOR_UNIT;
		up_sc = 32'(s_q.val_upper) * 32'(s_q.val_factor);
		lo_sc = 32'(s_q.val_lower) * 32'(s_q.val_factor);
		if (s_q.mode == ESM_RUN && (sig_sc > up_sc || sig_sc < lo_sc)) begin
			set_f[`ESM_F_MECH_LINK] = 1'b1;
		end

		// Motor versus external position difference
		s_d.pos_diff = esm_absdiff(enc[0].pos, enc[1].pos);
		if (s_q.diff_en && s_q.diff_win != 32'h0000_0000 && comm_phase >= `ESM_PHASE_FOUR
			&& s_q.pos_diff > s_q.diff_win) begin
			set_f[`ESM_F_EXC_DIFF] = 1'b1;
		end

		// Reference loss on entry to phase four
		if (ph4_entry && s_q.phase >= `ESM_PHASE_TWO) begin
			for (int i = 0; i < 2; i++) begin
				if (ref_lost[i] && s_q.enc_type[i][`ESM_TYPE_ABS_BIT]) begin
					s_d.pos_abs[i] = 1'b0;
					set_f[`ESM_F_MOT_REF + i] = 1'b1;
				end
			end
		end

		// APB slave, one wait state
		access = apb_req.psel && apb_req.penable;
		s_d.rsp.pready = 1'b0;
		s_d.rsp.pslverr = 1'b0;
		case (apb_req.paddr)
			`ESM_REG_CTRL: rd = {31'h0000_0000, s_q.diff_en};
			`ESM_REG_ENC1_TYPE: rd = {16'h0000, s_q.enc_type[0]};
			`ESM_REG_ENC2_TYPE: rd = {16'h0000, s_q.enc_type[1]};
			`ESM_REG_MEAS_TYPE: rd = {16'h0000, s_q.enc_type[2]};
			`ESM_REG_SINE_NOM: rd = {16'h0000, s_q.sine_nom};
			`ESM_REG_RES_SUPPLY: rd = {16'h0000, s_q.res_supply};
			`ESM_REG_RES_RATIO: rd = {16'h0000, s_q.res_ratio};
			`ESM_REG_MARK_DIST: rd = s_q.mark_dist;
			`ESM_REG_WIN1: rd = s_q.win[0];
			`ESM_REG_WIN2: rd = s_q.win[1];
			`ESM_REG_DIFF_WIN: rd = s_q.diff_win;
			`ESM_REG_VAL_UPPER: rd = {16'h0000, s_q.val_upper};
			`ESM_REG_VAL_LOWER: rd = {16'h0000, s_q.val_lower};
			`ESM_REG_VAL_FACTOR: rd = {16'h0000, s_q.val_factor};
			`ESM_REG_REACTION: rd = {30'h0000_0000, s_q.reaction_cfg};
			`ESM_REG_BUF1: rd = s_q.buf_pos[0];
			`ESM_REG_BUF2: rd = s_q.buf_pos[1];
			`ESM_REG_STATUS: rd = {19'h0_0000, s_q.flags};
			`ESM_REG_POS_DIFF: rd = s_q.pos_diff;
			`ESM_REG_POS_STAT: rd = {30'h0000_0000, s_q.pos_abs};
			default: hit = 1'b0;
		endcase
		if (access && !s_q.rsp.pready) begin
			// First access cycle: prepare the answer
			s_d.rsp.pready = 1'b1;
			s_d.rsp.pslverr = !hit;
			s_d.rsp.prdata = hit && !apb_req.pwrite ? rd : 32'h0000_0000;
		end else if (access && apb_req.pwrite && hit) begin
			// Write commits on the completing edge
			case (apb_req.paddr)
				`ESM_REG_CTRL: s_d.diff_en = apb_req.pwdata[`ESM_CTRL_DIFF_EN_BIT];
				`ESM_REG_ENC1_TYPE: s_d.enc_type[0] = apb_req.pwdata[15:0];
				`ESM_REG_ENC2_TYPE: s_d.enc_type[1] = apb_req.pwdata[15:0];
				`ESM_REG_MEAS_TYPE: s_d.enc_type[2] = apb_req.pwdata[15:0];
				`ESM_REG_SINE_NOM: s_d.sine_nom = apb_req.pwdata[15:0];
				`ESM_REG_RES_SUPPLY: s_d.res_supply = apb_req.pwdata[15:0];
				`ESM_REG_RES_RATIO: s_d.res_ratio = apb_req.pwdata[15:0];
				`ESM_REG_MARK_DIST: s_d.mark_dist = apb_req.pwdata;
				`ESM_REG_WIN1: s_d.win[0] = apb_req.pwdata;
				`ESM_REG_WIN2: s_d.win[1] = apb_req.pwdata;
				`ESM_REG_DIFF_WIN: s_d.diff_win = apb_req.pwdata;
				`ESM_REG_VAL_UPPER: s_d.val_upper = apb_req.pwdata[15:0];
				`ESM_REG_VAL_LOWER: s_d.val_lower = apb_req.pwdata[15:0];
				`ESM_REG_VAL_FACTOR: s_d.val_factor = apb_req.pwdata[15:0];
				`ESM_REG_REACTION: s_d.reaction_cfg = apb_req.pwdata[1:0];
				`ESM_REG_BUF1: s_d.buf_pos[0] = power_off ? enc[0].pos : apb_req.pwdata;
				`ESM_REG_BUF2: s_d.buf_pos[1] = power_off ? enc[1].pos : apb_req.pwdata;
				`ESM_REG_STATUS: clr_f = apb_req.pwdata[12:0] & ~`ESM_WARN_MASK;
				`ESM_REG_POS_STAT: s_d.pos_abs = s_d.pos_abs | apb_req.pwdata[1:0];
				default: clr_f = '0;
			endcase
		end

		// Warnings only clear on entry to phase two
		if (ph2_entry) begin
			clr_f = clr_f | `ESM_WARN_MASK;
		end
		// Sticky flags, a new event wins over a clear
		s_d.flags = (s_q.flags & ~clr_f) | set_f;
		// Error reaction follows any latched error
		s_d.reaction = |(s_d.flags & ~`ESM_WARN_MASK) ? s_q.reaction_cfg : 2'b00;
	end

	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
			s_q.mode <= ESM_RUN;
			s_q.sine_nom <= `ESM_RST_SINE_NOM;
			s_q.val_factor <= `ESM_RST_FACTOR;
			s_q.enc_type <= {3{`ESM_RST_TYPE}};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign apb_rsp = s_q.rsp;
	assign flags = s_q.flags;
	assign pos_abs = s_q.pos_abs;
	assign reaction = s_q.reaction;
endmodule : esm_top

/* verification/esm_enc_model.sv */
`timescale 1ns/1ps
// Encoder front ends: two analog trackers and one position-only encoder
module esm_enc_model (
	input wire logic mclk,
	input wire logic [1:0][15:0] amp_a,
	input wire logic [1:0][15:0] amp_b,
	input wire logic [2:0][31:0] pos,
	input wire logic [2:0] mark_go,
	output esm_pkg::esm_enc_t [2:0] enc
);
	import esm_pkg::*;
	// Conversion pacing, one sample every fourth cycle
	logic [1:0] div_q = 2'b00;
	// Tracks show junk between strobes so stale values are never trusted
	always @(posedge mclk) begin
		div_q <= div_q + 2'b01;
		for (int i = 0; i < 3; i++) begin
			enc[i].smp_valid <= (i != 2) && (div_q == 2'b00);
			enc[i].pos <= pos[i];
			enc[i].mark_valid <= mark_go[i];
			enc[i].mark_pos <= mark_go[i] ? pos[i] : ~pos[i];
		end
		for (int i = 0; i < 2; i++) begin
			enc[i].trk_a <= (div_q == 2'b00) ? amp_a[i] : ~amp_a[i];
			enc[i].trk_b <= (div_q == 2'b00) ? amp_b[i] : ~amp_b[i];
		end
		enc[2].trk_a <= {div_q, 14'h0000};
		enc[2].trk_b <= {14'h0000, div_q};
	end
endmodule : esm_enc_model

/* verification/esm_top_assertions.sv */
`timescale 1ns/1ps
// Port-level checks of the encoder monitor
module esm_top_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire esm_pkg::esm_apb_req_t apb_req,
	input wire esm_pkg::esm_apb_rsp_t apb_rsp,
	input wire logic [2:0] comm_phase,
	input wire logic [12:0] flags,
	input wire logic [1:0] pos_abs,
	input wire logic [1:0] reaction
);
	import esm_pkg::*;
	// Status write that clears the first error bit
	logic clr_hit;
	assign clr_hit = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == 8'h44 && apb_req.pwdata[2];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Access cycle still waiting
	sequence s_wait;
		apb_req.psel && apb_req.penable && !apb_rsp.pready;
	endsequence
	// Answer cycle
	sequence s_answer;
		apb_req.psel && apb_req.penable && apb_rsp.pready;
	endsequence
	a_one_wait: assert property (s_wait |=> s_answer) else $error("answer not after one wait");
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready held");
	a_err_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0000_0000) else $error("data on err");
	a_unmapped_err: assert property (apb_rsp.pready && apb_req.paddr[1:0] == 2'b00
		|-> apb_rsp.pslverr == (apb_req.paddr > 8'h4c)) else $error("error code wrong");
	a_warn_latched: assert property (comm_phase != 3'd2 |=> (flags[1:0] & $past(flags[1:0])) == $past(flags[1:0]))
		else $error("warning lost");
	a_warn_clear: assert property ($fell(flags[0]) |-> $past(comm_phase) == 3'd2) else $error("warn cleared");
	a_reaction_src: assert property (reaction != 2'b00 |-> flags[12:2] != 0 || $past(flags[12:2]) != 0)
		else $error("reaction without error");
	a_ref_loss: assert property ($fell(pos_abs[0]) |-> ##[0:1] flags[7]) else $error("no loss flag");
	a_err_w1c: assert property ($fell(flags[2]) |-> $past(clr_hit)) else $error("error dropped");
	a_diff_phase: assert property ($rose(flags[6]) |-> $past(comm_phase) >= 3'd4) else $error("early diff");
endmodule : esm_top_assertions
bind esm_top esm_top_assertions u_chk (.mclk(mclk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.comm_phase(comm_phase), .flags(flags), .pos_abs(pos_abs), .reaction(reaction));

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
	import esm_pkg::*;
	logic mclk = 1'b0;
	logic rst;
	esm_apb_req_t apb_req;
	esm_apb_rsp_t apb_rsp;
	esm_enc_t [2:0] enc;
	logic [1:0][15:0] amp_a, amp_b;
	logic [2:0][31:0] pos;
	logic [2:0] mark_go, comm_phase;
	logic power_off, power_on;
	logic [15:0] val_signal;
	logic [1:0] ref_lost, pos_abs, reaction;
	logic [12:0] flags;
	logic [32:0] exp_q[$];
	int err_count = 0, checks_done = 0, cycles = 0;
	integer seed = 32'hca1e6d46;
	logic [31:0] base;
	logic [15:0] amp_t[4] = '{16'h0334, 16'h1666, 16'h0333, 16'h1667};
	logic [15:0] res_t[4] = '{16'h0800, 16'h1333, 16'h07ff, 16'h1334};
	logic [15:0] val_t[4] = '{16'h03e8, 16'h0064, 16'h03e9, 16'h0063};
	always #2 mclk = ~mclk;
	esm_top DUT (.mclk(mclk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .enc(enc), .comm_phase(comm_phase),
		.power_off(power_off), .power_on(power_on), .val_signal(val_signal), .ref_lost(ref_lost), .flags(flags),
		.pos_abs(pos_abs), .reaction(reaction));
	esm_enc_model u_enc (.mclk(mclk), .amp_a(amp_a), .amp_b(amp_b), .pos(pos), .mark_go(mark_go), .enc(enc));
	// Compare and count
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic final_report;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	// One APB transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, w, ad, d};
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		// Idle edge so the next call never reassigns the request in this time step
		@(posedge mclk);
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask : wr
	// Read with the expected error bit and data noted first
	task automatic rd(input logic [7:0] ad, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, ad, 32'h0000_0000);
	endtask : rd
	task automatic st(input logic [12:0] f);
		rd(8'h44, {20'h0_0000, f});
	endtask : st
	// Clear errors by software, warnings by a visit to phase two
	task automatic clr;
		wr(8'h44, 32'h0000_1ffc);
		comm_phase <= 3'd2;
		cyc(4);
		comm_phase <= 3'd0;
		cyc(2);
	endtask : clr
	// Brief amplitude excursion on one encoder
	task automatic amp_case(input int e, input logic [15:0] v, input logic [12:0] f);
		amp_a[e] <= v;
		cyc(8);
		amp_a[e] <= 16'h1000;
		cyc(8);
		st(f);
		wr(8'h44, 32'h0000_1ffc);
		st(f);
		clr();
	endtask : amp_case
	task automatic quad(input logic [15:0] a, input logic [15:0] b);
		amp_a[0] <= a;
		amp_b[0] <= b;
		cyc(8);
	endtask : quad
	task automatic mk(input logic [31:0] p);
		pos[0] <= p;
		mark_go[0] <= 1'b1;
		cyc(1);
		mark_go[0] <= 1'b0;
		cyc(4);
	endtask : mk
	// Result watcher: each read answer against the oldest note
	always @(posedge mclk) begin
		if (apb_rsp.pready === 1'b1 && apb_req.pwrite === 1'b0 && exp_q.size() > 0) begin
			check({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
		end
	end
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		apb_req <= '0;
		amp_a <= {16'h1000, 16'h1000};
		amp_b <= '0;
		pos <= '0;
		mark_go <= '0;
		comm_phase <= 3'd0;
		{power_off, power_on, ref_lost, val_signal} <= '0;
		rst <= 1'b1;
		cyc(3);
		rst <= 1'b0;
		rd(8'h10, 33'h0_0000_1000);
		rd(8'h34, 33'h0_0000_0008);
		rd(8'h50, 33'h1_0000_0000);
		base = $random(seed);
		wr(8'h1c, base);
		rd(8'h1c, {1'b0, base});
		for (int i = 0; i < 4; i++) amp_case(0, amp_t[i], (i > 1) ? 13'h0001 : 13'h0000);
		wr(8'h38, 32'h0000_0002);
		amp_a[0] <= 16'h0064;
		cyc(80);
		amp_a[0] <= 16'h1000;
		cyc(8);
		st(13'h0005);
		check({31'h0, reaction}, 33'h0_0000_0002);
		clr();
		check({31'h0, reaction}, 33'h0_0000_0000);
		quad(16'h0b50, 16'h0b50);
		quad(16'hf4b0, 16'h0b50);
		quad(16'hf4b0, 16'hf4b0);
		st(13'h0000);
		quad(16'h0b50, 16'h0b50);
		st(13'h0004);
		clr();
		quad(16'h1000, 16'h0000);
		wr(8'h14, 32'h0000_1000);
		wr(8'h18, 32'h0000_0100);
		wr(8'h08, 32'h0000_0001);
		for (int i = 0; i < 4; i++) amp_case(1, res_t[i], (i > 1) ? 13'h0002 : 13'h0000);
		wr(8'h04, 32'h0000_0002);
		amp_a[0] <= 16'h0000;
		cyc(80);
		st(13'h0000);
		wr(8'h1c, 32'h0000_0064);
		wr(8'h04, 32'h0000_0203);
		amp_a[0] <= 16'h1000;
		mk(32'h0000_0000);
		mk(32'h0000_0064);
		pos[0] <= 32'h0000_00fa;
		cyc(4);
		st(13'h0000);
		pos[0] <= 32'h0000_00fb;
		cyc(4);
		st(13'h0400);
		mk(32'h0000_00c8);
		clr();
		mk(32'h0000_012b);
		st(13'h0400);
		clr();
		wr(8'h04, 32'h0000_0003);
		pos[0] <= 32'h0000_1388;
		cyc(4);
		st(13'h0000);
		wr(8'h04, 32'h0000_0100);
		wr(8'h08, 32'h0000_0101);
		wr(8'h20, 32'h0000_000a);
		for (int i = 0; i < 2; i++) begin
			pos <= {32'h0000_0000, 32'h0000_1388, 32'h0000_03e8};
			cyc(2);
			power_off <= 1'b1;
			cyc(1);
			power_off <= 1'b0;
			pos <= {32'h0000_0000, 32'h0000_2328, 32'h0000_03f2 + 32'(i)};
			rd(8'h3c, 33'h0_0000_03e8);
			rd(8'h40, 33'h0_0000_1388);
			power_on <= 1'b1;
			cyc(1);
			power_on <= 1'b0;
			cyc(2);
			st((i > 0) ? 13'h0010 : 13'h0000);
			clr();
		end
		wr(8'h2c, 32'h0000_03e8);
		val_signal <= 16'h01f4;
		wr(8'h30, 32'h0000_0064);
		for (int i = 0; i < 4; i++) begin
			val_signal <= val_t[i];
			cyc(4);
			val_signal <= 16'h01f4;
			cyc(2);
			st((i > 1) ? 13'h0200 : 13'h0000);
			clr();
		end
		wr(8'h34, 32'h0000_0010);
		val_signal <= 16'h05dc;
		cyc(4);
		st(13'h0000);
		base = $random(seed) & 32'h00ff_ffff;
		wr(8'h00, 32'h0000_0001);
		wr(8'h28, 32'h0000_0032);
		pos <= {32'h0000_0000, base + 32'h0000_0033, base};
		comm_phase <= 3'd3;
		cyc(4);
		st(13'h0000);
		rd(8'h48, 33'h0_0000_0033);
		comm_phase <= 3'd4;
		cyc(4);
		st(13'h0040);
		pos[1] <= base + 32'h0000_0032;
		clr();
		comm_phase <= 3'd4;
		cyc(4);
		st(13'h0000);
		wr(8'h00, 32'h0000_0000);
		pos[1] <= base + 32'h0000_0033;
		cyc(4);
		st(13'h0000);
		wr(8'h4c, 32'h0000_0001);
		rd(8'h4c, 33'h0_0000_0001);
		ref_lost <= 2'b01;
		comm_phase <= 3'd2;
		cyc(4);
		comm_phase <= 3'd4;
		cyc(4);
		rd(8'h4c, 33'h0_0000_0000);
		st(13'h0080);
		final_report();
	end
endmodule : tb
